// file: test/ppfs_pin_model.sv
// Pin-side model: outside devices that share the first-port pins
`timescale 1ns/1ps
`default_nettype none

module ppfs_pin_model (
  input  wire logic [11:0] drv_i,     // Block drive level
  input  wire logic [11:0] drv_oe_i,  // Block drive enable
  input  wire logic [11:0] ext_i,     // Level the outside device drives
  output logic      [11:0] pin_o      // Resolved pin level
);
  // ----
  // Pin resolution
  // ----
  // Outside device yields where the block drives, so no contention is modelled
  assign pin_o = (drv_oe_i & drv_i) | (~drv_oe_i & ext_i);
endmodule

`default_nettype wire

// file: test/testbench.sv
// Self-checking bench of the port pin function select block
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import ppfs_pkg::*;
  // ----
  // Stimulus and observed signals
  // ----
  logic        sys_clk_i  = 1'b0;
  logic        rst_b_i    = 1'b0;
  logic        strap      = 1'b0;     // Expansion boot, ROM off
  logic        clk_en     = 1'b1;     // Block clock enable
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [11:0] paddr      = 12'h000;
  logic [31:0] pwdata     = 32'h0;
  logic [11:0] pa_out     = 12'h000;  // Port logic drive
  logic [11:0] pa_oe      = 12'h000;
  logic [11:0] ext        = 12'h000;  // Outside device level
  logic [3:0]  cs         = 4'h0;
  logic [1:0]  txd        = 2'h0;
  logic [1:0]  sco        = 2'h0;
  logic [1:0]  scoe       = 2'h0;
  logic [9:0]  gpio       = 10'h000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err;
  logic [11:0] pin_i, pin_o, pin_oe, pa_in, e_out, e_oe, lvl;
  logic [3:0]  tclk, irq, e_tclk, e_irq;
  logic [1:0]  dreq, rxd, sck, e_dreq, e_rxd, e_sck;
  logic [9:0]  pb_oe;
  logic [15:0] fs1, fs2, dir;
  integer      seed       = 32'h1551032c;
  int          fail_count = 0;
  int          n_compared = 0;

  always #50 sys_clk_i = ~sys_clk_i;  // 10 MHz

  ppfs_top i_dut (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .sys_clk_en_i(clk_en),
    .boot_ext_norom_i(strap), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .pa_pin_i(pin_i), .pa_pin_o(pin_o), .pa_pin_oe_o(pin_oe),
    .port_a_out_i(pa_out), .port_a_oe_i(pa_oe), .port_a_in_o(pa_in),
    .chip_select_i(cs), .timer_ext_clock_o(tclk), .int_request_o(irq),
    .dma_request_o(dreq), .serial_transmit_i(txd), .serial_clock_out_i(sco),
    .serial_clock_oe_i(scoe), .serial_clock_in_o(sck), .serial_receive_o(rxd),
    .port_b_gpio_mode_i(gpio), .port_b_pin_oe_o(pb_oe));

  ppfs_pin_model i_pins (.drv_i(pin_o), .drv_oe_i(pin_oe), .ext_i(ext), .pin_o(pin_i));

  // ----
  // Verdict and comparison
  // ----
  task automatic print_verdict();
    if (fail_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ----
  // APB master: holds the request until pready is sampled high
  // ----
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    bit got;
    got = 1'b0;
    @(posedge sys_clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    // Answer taken at the very edge that samples pready high
    for (int n = 0; n < 16 && !got; n++) begin
      @(posedge sys_clk_i);
      if (pready === 1'b1) begin
        got = 1'b1;
        rd  = prdata;
        err = pslverr;
      end
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    if (!got) begin
      fail_count++;
      print_verdict();
    end
  endtask

  // ----
  // Expected routing, from the selection fields
  // ----
  function automatic logic [1:0] mx(input logic [1:0] f, input logic [1:0] p, a1, a2, a3);
    return (f == 2'h0) ? p : (f == 2'h1) ? a1 : (f == 2'h2) ? a2 : a3;
  endfunction

  function automatic logic [1:0] pt(input int i);
    return {pa_oe[i], pa_out[i]};
  endfunction

  task automatic calc();
    {e_oe[11], e_out[11]} = mx({1'b0, fs1[6]}, pt(11), {1'b1, cs[1]}, 2'h0, 2'h0);
    {e_oe[10], e_out[10]} = mx({1'b0, fs1[4]}, pt(10), {1'b1, cs[0]}, 2'h0, 2'h0);
    {e_oe[9], e_out[9]}   = mx(fs1[3:2], pt(9), 2'h0, 2'h0, 2'h0);
    {e_oe[8], e_out[8]}   = mx(fs1[1:0], pt(8), 2'h0, 2'h0, 2'h0);
    {e_oe[7], e_out[7]}   = mx(fs2[15:14], pt(7), 2'h0, {1'b1, cs[3]}, 2'h0);
    {e_oe[6], e_out[6]}   = mx(fs2[13:12], pt(6), 2'h0, {1'b1, cs[2]}, 2'h0);
    {e_oe[5], e_out[5]}   = mx(fs2[11:10], pt(5), {scoe[1], sco[1]}, 2'h0, 2'h0);
    {e_oe[4], e_out[4]}   = mx({1'b0, fs2[8]}, pt(4), {1'b1, txd[1]}, 2'h0, 2'h0);
    {e_oe[3], e_out[3]}   = mx({1'b0, fs2[6]}, pt(3), 2'h0, 2'h0, 2'h0);
    {e_oe[2], e_out[2]}   = mx(fs2[5:4], pt(2), {scoe[0], sco[0]}, 2'h0, 2'h0);
    {e_oe[1], e_out[1]}   = mx({1'b0, fs2[2]}, pt(1), {1'b1, txd[0]}, 2'h0, 2'h0);
    {e_oe[0], e_out[0]}   = mx({1'b0, fs2[0]}, pt(0), 2'h0, 2'h0, 2'h0);
    lvl    = (e_oe & e_out) | (~e_oe & ext);
    // Deselected: clocks idle low, requests and receive idle high
    e_tclk = {fs1[3:2] == 2'h1 && lvl[9], fs1[1:0] == 2'h1 && lvl[8],
              fs2[15:14] == 2'h1 && lvl[7], fs2[13:12] == 2'h1 && lvl[6]};
    e_irq  = {fs1[3:2] != 2'h2 || lvl[9], fs1[1:0] != 2'h2 || lvl[8],
              fs2[11:10] != 2'h3 || lvl[5], fs2[5:4] != 2'h3 || lvl[2]};
    e_dreq = {fs2[11:10] != 2'h2 || lvl[5], fs2[5:4] != 2'h2 || lvl[2]};
    e_rxd  = {!fs2[6] || lvl[3], !fs2[0] || lvl[0]};
    e_sck  = {fs2[11:10] == 2'h1 && lvl[5], fs2[5:4] == 2'h1 && lvl[2]};
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    apb(1'b0, PPFS_FS1_OFF, 32'h0);
    chk("fs1_reset", 32'h0, rd);
    apb(1'b0, PPFS_DIR_OFF, 32'h0);
    chk("dir_reset", 32'h0, rd);
    // Reserved bits dropped; no forbidden code on pins 9..6
    apb(1'b1, PPFS_FS1_OFF, 32'hfffffff5);
    apb(1'b0, PPFS_FS1_OFF, 32'h0);
    chk("fs1_bits", 32'h00000055, rd);
    apb(1'b1, PPFS_FS2_OFF, 32'hffff5fff);
    apb(1'b0, PPFS_FS2_OFF, 32'h0);
    chk("fs2_bits", 32'h00005d75, rd);
    apb(1'b1, PPFS_DIR_OFF, 32'hffffffff);
    apb(1'b0, PPFS_DIR_OFF, 32'h0);
    chk("dir_bits", 32'h000003ff, rd);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped_err", 32'h1, 32'(err));
    // New selection shows one cycle after the write settles
    apb(1'b1, PPFS_FS2_OFF, 32'h0);
    repeat (3) @(posedge sys_clk_i);
    apb(1'b1, PPFS_FS2_OFF, 32'h4);
    @(negedge sys_clk_i);
    chk("pin1_oe_old", 32'h0, 32'(pin_oe[1]));
    @(negedge sys_clk_i);
    chk("pin1_oe_new", 32'h1, 32'(pin_oe[1]));
    // Random legal selections against random surroundings
    for (int i = 0; i < 40; i++) begin
      fs1 = 16'($random(seed)) & 16'h005f;
      fs2 = 16'($random(seed)) & 16'hfd75;
      dir = 16'($random(seed)) & 16'h03ff;  // Reserved direction bits written as zero
      if (fs1[3:2] == 2'h3) fs1[3] = 1'b0;
      if (fs1[1:0] == 2'h3) fs1[1] = 1'b0;
      if (fs2[15:14] == 2'h3) fs2[15] = 1'b0;
      if (fs2[13:12] == 2'h3) fs2[13] = 1'b0;
      apb(1'b1, PPFS_FS1_OFF, {16'h0, fs1});
      apb(1'b1, PPFS_FS2_OFF, {16'h0, fs2});
      apb(1'b1, PPFS_DIR_OFF, {16'h0, dir});
      apb(1'b0, PPFS_FS2_OFF, 32'h0);
      chk("fs2_read", {16'h0, fs2}, rd);
      @(posedge sys_clk_i);
      pa_out <= 12'($random(seed));
      pa_oe  <= 12'($random(seed));
      ext    <= 12'($random(seed));
      cs     <= 4'($random(seed));
      {txd, sco, scoe} <= 6'($random(seed));
      gpio   <= 10'($random(seed));
      // Pin inputs need two sync stages plus the routing register
      repeat (5) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      calc();
      chk("pin_oe", 32'(e_oe), 32'(pin_oe));
      chk("pin_out", 32'(e_out & e_oe), 32'(pin_o & e_oe));
      chk("port_in", 32'(lvl), 32'(pa_in));
      chk("tclk", 32'(e_tclk), 32'(tclk));
      chk("irq", 32'(e_irq), 32'(irq));
      chk("dreq", 32'(e_dreq), 32'(dreq));
      chk("rxd", 32'(e_rxd), 32'(rxd));
      chk("sck_in", 32'(e_sck), 32'(sck));
      chk("pb_oe", 32'(dir[9:0] & gpio), 32'(pb_oe));
    end
    // Clock enable low: routing frozen although port drive changes
    @(posedge sys_clk_i);
    clk_en <= 1'b0;
    pa_oe  <= ~pa_oe;
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk("freeze_oe", 32'(e_oe), 32'(pin_oe));
    // Second reset with expansion boot: chip selects from the start
    @(posedge sys_clk_i);
    rst_b_i <= 1'b0;
    clk_en  <= 1'b1;
    strap   <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    apb(1'b0, PPFS_FS1_OFF, 32'h0);
    chk("fs1_strap", 32'h00000050, rd);
    apb(1'b0, PPFS_DIR_OFF, 32'h0);
    chk("dir_reset2", 32'h0, rd);
    chk("cs_pins_oe", 32'h3, 32'(pin_oe[11:10]));
    chk("cs_pins_out", 32'({cs[1], cs[0]}), 32'(pin_o[11:10]));
    print_verdict();
  end
endmodule

`default_nettype wire

// file: verilog/ppfs_pkg.sv
// Constants, register map and state record of the port pin function select block
package ppfs_pkg;

  // ----------------------------------------------------------------
  // Register map (APB byte addresses)
  // ----------------------------------------------------------------
  localparam int          PPFS_ADDR_W     = 12;        // Decoded address width
  localparam logic [11:0] PPFS_FS1_OFF    = 12'h000;   // port_a_low_function_select_1
  localparam logic [11:0] PPFS_FS2_OFF    = 12'h004;   // port_a_low_function_select_2
  localparam logic [11:0] PPFS_DIR_OFF    = 12'h008;   // port_b_direction

  // ----------------------------------------------------------------
  // Implemented bits, reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] PPFS_FS1_MASK   = 16'h005f;  // Bits 6, 4, 3:0 stored
  localparam logic [15:0] PPFS_FS2_MASK   = 16'hfd75;  // Bits 15:10, 8, 6, 5:4, 2, 0
  localparam logic [15:0] PPFS_DIR_MASK   = 16'h03ff;  // Bits 9:0, rest read zero
  localparam logic [15:0] PPFS_FS_RST     = 16'h0000;  // Selection reset value
  localparam logic [15:0] PPFS_DIR_RST    = 16'h0000;  // All second-port pins inputs

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PPFS_PIN11_BIT = 6;   // In select 1
  localparam int PPFS_PIN10_BIT = 4;   // In select 1
  localparam int PPFS_PIN9_LO   = 2;   // In select 1, two bits
  localparam int PPFS_PIN8_LO   = 0;   // In select 1, two bits
  localparam int PPFS_PIN7_LO   = 14;  // In select 2, two bits
  localparam int PPFS_PIN6_LO   = 12;  // In select 2, two bits
  localparam int PPFS_PIN5_LO   = 10;  // In select 2, two bits
  localparam int PPFS_PIN4_BIT  = 8;   // In select 2
  localparam int PPFS_PIN3_BIT  = 6;   // In select 2
  localparam int PPFS_PIN2_LO   = 4;   // In select 2, two bits
  localparam int PPFS_PIN1_BIT  = 2;   // In select 2
  localparam int PPFS_PIN0_BIT  = 0;   // In select 2

  // ----------------------------------------------------------------
  // Selection codes and idle levels
  // ----------------------------------------------------------------
  localparam logic [1:0] PPFS_SEL_PORT = 2'h0;  // General port
  localparam logic [1:0] PPFS_SEL_ALT1 = 2'h1;  // First alternate
  localparam logic [1:0] PPFS_SEL_ALT2 = 2'h2;  // Second alternate
  localparam logic [1:0] PPFS_SEL_ALT3 = 2'h3;  // Third alternate
  localparam logic       PPFS_IDLE_HI  = 1'b1;  // Idle level of active-low requests
  localparam logic       PPFS_IDLE_LO  = 1'b0;  // Idle level of clocks
  localparam logic [15:0] PPFS_ZERO16  = 16'h0000;

  // ----------------------------------------------------------------
  // Whole state of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] fs1;        // Select register 1
    logic [15:0] fs2;        // Select register 2
    logic [15:0] dir;        // Second-port direction
    logic [31:0] prdata;     // Read data
    logic        pready;     // Access answer
    logic        pslverr;    // Unmapped address
    logic [11:0] pin_s1;     // Pin synchroniser stage 1
    logic [11:0] pin_s2;     // Pin synchroniser stage 2
    logic        strap_s1;   // Boot strap stage 1
    logic        strap_s2;   // Boot strap stage 2
    logic [11:0] pa_out;     // Pin output level
    logic [11:0] pa_oe;      // Pin output enable
    logic [11:0] pa_in;      // Pin level to port logic
    logic [3:0]  tclk;       // Timer clocks a..d
    logic [3:0]  irq;        // Interrupt requests 0..3
    logic [1:0]  dreq;       // DMA requests 0..1
    logic [1:0]  rxd;        // Serial receive 0..1
    logic [1:0]  sck_in;     // Serial clock in 0..1
    logic [9:0]  pb_oe;      // Second-port output enables
  } ppfs_state_t;

endpackage

// file: verilog/ppfs_top.sv
// Port pin function select: APB registers, pin routing, second-port direction
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Pin eleven: port or chip select 1
// - Pin ten: port or chip select 0
// - Pin nine: port, timer clock D, IRQ 3
// - Pin eight: port, timer clock C, IRQ 2
// - Pin seven: port, timer clock B, select 3
// - Pin six: port, timer clock A, select 2
// - Pin five: port, clock1, DMA1, INT_REQUEST_1
// - Pin four: port or serial 1 transmit
// - Pin three: port or serial 1 receive
// - Pin two: port, clock0, DMA0, INT_REQUEST_0
// - Pin one: port or serial 0 transmit
// - Pin zero: port or serial 0 receive
// - Pins eleven, ten reset by boot strap
// - Direction register is 16-bit read/write
// - Direction bit one means output
// - Direction only acts in port mode
// - Direction bits 15:10 read zero
// - Direction register resets to zero
module ppfs_top
  import ppfs_pkg::*;
#(
  parameter int ADDR_W = PPFS_ADDR_W               // APB address width
) (
  input  wire logic              sys_clk_i,         // 10 MHz peripheral clock
  input  wire logic              rst_b_i,           // Synchronous reset, low
  input  wire logic              sys_clk_en_i,      // Low freezes all state unless reset is held
  input  wire logic              boot_ext_norom_i,  // Strap: expansion, ROM off
  // APB slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // First-port pins 11..0
  input  wire logic [11:0]       pa_pin_i,          // Pin level
  output logic      [11:0]       pa_pin_o,          // Pin drive level
  output logic      [11:0]       pa_pin_oe_o,       // Pin drive enable
  // General port logic
  input  wire logic [11:0]       port_a_out_i,      // Port data out
  input  wire logic [11:0]       port_a_oe_i,       // Port direction
  output logic      [11:0]       port_a_in_o,       // Port data in
  // Bus controller
  input  wire logic [3:0]        chip_select_i,     // Chip selects 0..3
  // Timer, interrupt and DMA inputs
  output logic      [3:0]        timer_ext_clock_o, // Timer clocks a..d
  output logic      [3:0]        int_request_o,     // Interrupt requests 0..3
  output logic      [1:0]        dma_request_o,     // DMA requests 0..1
  // Serial channels
  input  wire logic [1:0]        serial_transmit_i, // Transmit data 0..1
  input  wire logic [1:0]        serial_clock_out_i,// Clock out 0..1
  input  wire logic [1:0]        serial_clock_oe_i, // Clock drive 0..1
  output logic      [1:0]        serial_clock_in_o, // Clock in 0..1
  output logic      [1:0]        serial_receive_o,  // Receive data 0..1
  // Second port
  input  wire logic [9:0]        port_b_gpio_mode_i,// Pin in port mode
  output logic      [9:0]        port_b_pin_oe_o    // Pin output enable
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ppfs_state_t st_reg;    // Current state
  ppfs_state_t st_next;   // Next state

  // ----------------------------------------------------------------
  // Bus decode helpers
  // ----------------------------------------------------------------
  logic apb_setup;        // Setup cycle
  logic apb_done;         // Access edge with answer
  logic [11:0] adr;       // Address trimmed to map width

  assign adr       = 12'(paddr_i);
  assign apb_setup = psel_i && !penable_i;
  assign apb_done  = psel_i && penable_i && st_reg.pready;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // No wait state: answer prepared in setup, taken on next edge
  always_comb begin
    logic [1:0] s9;
    logic [1:0] s8;
    logic [1:0] s7;
    logic [1:0] s6;
    logic [1:0] s5;
    logic [1:0] s2;
    logic [15:0] rd;
    s9 = st_reg.fs1[PPFS_PIN9_LO +: 2];
    s8 = st_reg.fs1[PPFS_PIN8_LO +: 2];
    s7 = st_reg.fs2[PPFS_PIN7_LO +: 2];
    s6 = st_reg.fs2[PPFS_PIN6_LO +: 2];
    s5 = st_reg.fs2[PPFS_PIN5_LO +: 2];
    s2 = st_reg.fs2[PPFS_PIN2_LO +: 2];
    rd = PPFS_ZERO16;
    st_next = st_reg;

    // Synchronisers: stage 1 feeds only stage 2
    st_next.pin_s1   = pa_pin_i;
    st_next.pin_s2   = st_reg.pin_s1;
    st_next.strap_s1 = boot_ext_norom_i;
    st_next.strap_s2 = st_reg.strap_s1;

    // Register read and error answer
    st_next.pready  = 1'b0;
    st_next.pslverr = 1'b0;
    if (apb_setup) begin
      st_next.pready = 1'b1;
      if (adr == PPFS_FS1_OFF) begin
        rd = st_reg.fs1 & PPFS_FS1_MASK;
      end else if (adr == PPFS_FS2_OFF) begin
        rd = st_reg.fs2 & PPFS_FS2_MASK;
      end else if (adr == PPFS_DIR_OFF) begin
        rd = st_reg.dir & PPFS_DIR_MASK;
      end else begin
        st_next.pslverr = 1'b1;                   // Unmapped: error, reads zero
      end
      st_next.prdata = 32'(rd);
    end

    // Register write at the access edge only
    if (apb_done && pwrite_i) begin
      if (adr == PPFS_FS1_OFF) begin
        st_next.fs1 = pwdata_i[15:0] & PPFS_FS1_MASK;
      end else if (adr == PPFS_FS2_OFF) begin
        st_next.fs2 = pwdata_i[15:0] & PPFS_FS2_MASK;
      end else if (adr == PPFS_DIR_OFF) begin
        st_next.dir = pwdata_i[15:0] & PPFS_DIR_MASK;
      end
    end

    // Default routing: port logic owns every pin
    st_next.pa_out  = port_a_out_i;
    st_next.pa_oe   = port_a_oe_i;
    st_next.pa_in   = st_reg.pin_s2;
    st_next.tclk    = {4{PPFS_IDLE_LO}};
    st_next.irq     = {4{PPFS_IDLE_HI}};
    st_next.dreq    = {2{PPFS_IDLE_HI}};
    st_next.rxd     = {2{PPFS_IDLE_HI}};
    st_next.sck_in  = {2{PPFS_IDLE_LO}};

    // Pin eleven
    if (st_reg.fs1[PPFS_PIN11_BIT]) begin
      st_next.pa_out[11] = chip_select_i[1];
      st_next.pa_oe[11]  = 1'b1;
    end
    // Pin ten
    if (st_reg.fs1[PPFS_PIN10_BIT]) begin
      st_next.pa_out[10] = chip_select_i[0];
      st_next.pa_oe[10]  = 1'b1;
    end
    // Pin nine; reserved code left on the port
    if (s9 == PPFS_SEL_ALT1) begin
      st_next.pa_oe[9] = 1'b0;
      st_next.tclk[3]  = st_reg.pin_s2[9];
    end else if (s9 == PPFS_SEL_ALT2) begin
      st_next.pa_oe[9] = 1'b0;
      st_next.irq[3]   = st_reg.pin_s2[9];
    end
    // Pin eight
    if (s8 == PPFS_SEL_ALT1) begin
      st_next.pa_oe[8] = 1'b0;
      st_next.tclk[2]  = st_reg.pin_s2[8];
    end else if (s8 == PPFS_SEL_ALT2) begin
      st_next.pa_oe[8] = 1'b0;
      st_next.irq[2]   = st_reg.pin_s2[8];
    end
    // Pin seven
    if (s7 == PPFS_SEL_ALT1) begin
      st_next.pa_oe[7] = 1'b0;
      st_next.tclk[1]  = st_reg.pin_s2[7];
    end else if (s7 == PPFS_SEL_ALT2) begin
      st_next.pa_out[7] = chip_select_i[3];
      st_next.pa_oe[7]  = 1'b1;
    end
    // Pin six
    if (s6 == PPFS_SEL_ALT1) begin
      st_next.pa_oe[6] = 1'b0;
      st_next.tclk[0]  = st_reg.pin_s2[6];
    end else if (s6 == PPFS_SEL_ALT2) begin
      st_next.pa_out[6] = chip_select_i[2];
      st_next.pa_oe[6]  = 1'b1;
    end
    // Pin five: clock is two-way, direction from the serial channel
    if (s5 == PPFS_SEL_ALT1) begin
      st_next.pa_out[5]  = serial_clock_out_i[1];
      st_next.pa_oe[5]   = serial_clock_oe_i[1];
      st_next.sck_in[1]  = st_reg.pin_s2[5];
    end else if (s5 == PPFS_SEL_ALT2) begin
      st_next.pa_oe[5] = 1'b0;
      st_next.dreq[1]  = st_reg.pin_s2[5];
    end else if (s5 == PPFS_SEL_ALT3) begin
      st_next.pa_oe[5] = 1'b0;
      st_next.irq[1]   = st_reg.pin_s2[5];
    end
    // Pin four
    if (st_reg.fs2[PPFS_PIN4_BIT]) begin
      st_next.pa_out[4] = serial_transmit_i[1];
      st_next.pa_oe[4]  = 1'b1;
    end
    // Pin three
    if (st_reg.fs2[PPFS_PIN3_BIT]) begin
      st_next.pa_oe[3] = 1'b0;
      st_next.rxd[1]   = st_reg.pin_s2[3];
    end
    // Pin two
    if (s2 == PPFS_SEL_ALT1) begin
      st_next.pa_out[2]  = serial_clock_out_i[0];
      st_next.pa_oe[2]   = serial_clock_oe_i[0];
      st_next.sck_in[0]  = st_reg.pin_s2[2];
    end else if (s2 == PPFS_SEL_ALT2) begin
      st_next.pa_oe[2] = 1'b0;
      st_next.dreq[0]  = st_reg.pin_s2[2];
    end else if (s2 == PPFS_SEL_ALT3) begin
      st_next.pa_oe[2] = 1'b0;
      st_next.irq[0]   = st_reg.pin_s2[2];
    end
    // Pin one
    if (st_reg.fs2[PPFS_PIN1_BIT]) begin
      st_next.pa_out[1] = serial_transmit_i[0];
      st_next.pa_oe[1]  = 1'b1;
    end
    // Pin zero
    if (st_reg.fs2[PPFS_PIN0_BIT]) begin
      st_next.pa_oe[0] = 1'b0;
      st_next.rxd[0]   = st_reg.pin_s2[0];
    end

    // Second port: direction gated by port mode
    st_next.pb_oe = st_reg.dir[9:0] & port_b_gpio_mode_i;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Routing is registered so a select change never glitches a pin
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      st_reg          <= '0;
      st_reg.fs1      <= PPFS_FS_RST;
      st_reg.fs2      <= PPFS_FS_RST;
      st_reg.dir      <= PPFS_DIR_RST;
      // Strap is synchronised, so it is caught while reset is held
      st_reg.fs1[PPFS_PIN11_BIT] <= st_reg.strap_s2;
      st_reg.fs1[PPFS_PIN10_BIT] <= st_reg.strap_s2;
      st_reg.strap_s1 <= boot_ext_norom_i;
      st_reg.strap_s2 <= st_reg.strap_s1;
      st_reg.irq      <= {4{PPFS_IDLE_HI}};
      st_reg.dreq     <= {2{PPFS_IDLE_HI}};
      st_reg.rxd      <= {2{PPFS_IDLE_HI}};
    end else if (sys_clk_en_i) begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign prdata_o          = st_reg.prdata;
  assign pready_o          = st_reg.pready;
  assign pslverr_o         = st_reg.pslverr;
  assign pa_pin_o          = st_reg.pa_out;
  assign pa_pin_oe_o       = st_reg.pa_oe;
  assign port_a_in_o       = st_reg.pa_in;
  assign timer_ext_clock_o = st_reg.tclk;
  assign int_request_o     = st_reg.irq;
  assign dma_request_o     = st_reg.dreq;
  assign serial_clock_in_o = st_reg.sck_in;
  assign serial_receive_o  = st_reg.rxd;
  assign port_b_pin_oe_o   = st_reg.pb_oe;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_PIN11_CS: assert property (
    (rst_b_i && sys_clk_en_i && st_reg.fs1[PPFS_PIN11_BIT]) |=>
      (pa_pin_oe_o[11] && pa_pin_o[11] == $past(chip_select_i[1])))
    else $error("Pin 11 not driving chip select 1");

  AST_PIN10_PORT: assert property (
    (rst_b_i && sys_clk_en_i && !st_reg.fs1[PPFS_PIN10_BIT]) |=>
      (pa_pin_o[10] == $past(port_a_out_i[10]) && pa_pin_oe_o[10] == $past(port_a_oe_i[10])))
    else $error("Pin 10 not following port logic");

  AST_PIN9_IRQ: assert property (
    (sys_clk_en_i && st_reg.fs1[PPFS_PIN9_LO +: 2] == PPFS_SEL_ALT2) |=>
      (!pa_pin_oe_o[9] && int_request_o[3] == $past(st_reg.pin_s2[9])))
    else $error("Pin 9 not routed to interrupt 3");

  AST_PIN8_TCLK: assert property (
    (sys_clk_en_i && st_reg.fs1[PPFS_PIN8_LO +: 2] == PPFS_SEL_ALT1) |=>
      (!pa_pin_oe_o[8] && timer_ext_clock_o[2] == $past(st_reg.pin_s2[8])))
    else $error("Pin 8 not routed to timer clock C");

  AST_PIN7_CS3: assert property (
    (sys_clk_en_i && st_reg.fs2[PPFS_PIN7_LO +: 2] == PPFS_SEL_ALT2) |=>
      (pa_pin_oe_o[7] && pa_pin_o[7] == $past(chip_select_i[3])))
    else $error("Pin 7 not driving chip select 3");

  AST_PIN5_DREQ: assert property (
    (sys_clk_en_i && st_reg.fs2[PPFS_PIN5_LO +: 2] == PPFS_SEL_ALT2) |=>
      (!pa_pin_oe_o[5] && dma_request_o[1] == $past(st_reg.pin_s2[5])))
    else $error("Pin 5 not routed to DMA request 1");

  AST_PIN0_RXD: assert property (
    (sys_clk_en_i && st_reg.fs2[PPFS_PIN0_BIT]) |=>
      (!pa_pin_oe_o[0] && serial_receive_o[0] == $past(st_reg.pin_s2[0])))
    else $error("Pin 0 not routed to serial 0 receive");

  AST_STRAP_RESET: assert property (
    (!$past(rst_b_i)) |->
      (st_reg.fs1[PPFS_PIN11_BIT] == $past(st_reg.strap_s2)))
    else $error("Chip select default does not follow boot strap");

  AST_DIR_READ_RSVD: assert property (
    (sys_clk_en_i && apb_setup && adr == PPFS_DIR_OFF) |=>
      (pready_o && prdata_o[15:10] == 6'h00 && prdata_o[9:0] == $past(st_reg.dir[9:0])))
    else $error("Direction read wrong or reserved bits set");

  AST_DIR_RESET: assert property (
    (!$past(rst_b_i)) |-> (st_reg.dir == PPFS_DIR_RST))
    else $error("Direction register not cleared by reset");

  AST_PB_GATE: assert property (
    sys_clk_en_i |=>
      (port_b_pin_oe_o == ($past(st_reg.dir[9:0]) & $past(port_b_gpio_mode_i))))
    else $error("Second-port enable not gated by port mode");

  AST_WRITE_ROUTE: assert property (
    (sys_clk_en_i && apb_done && pwrite_i && adr == PPFS_FS2_OFF && pwdata_i[PPFS_PIN4_BIT])
      ##1 sys_clk_en_i |=> pa_pin_oe_o[4])
    else $error("Transmit routing late after select write");

  COV_DIR_WRITE: cover property (apb_done && pwrite_i && adr == PPFS_DIR_OFF);
  COV_PIN5_IRQ:  cover property (st_reg.fs2[PPFS_PIN5_LO +: 2] == PPFS_SEL_ALT3);
  COV_UNMAPPED:  cover property (pready_o && pslverr_o);

endmodule

`default_nettype wire
